// ==== rqi_rx_queue_flags.sv ====
`timescale 1ns/1ps
module rqi_rx_queue_flags
  import rqi_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   bus_reset,
  input  wire logic                   req_xfer_error,
  input  wire logic                   rsp_xfer_error,
  input  wire logic                   req_quadlet_avail,
  input  wire logic                   rsp_quadlet_avail,
  input  wire logic                   req_read_req,
  input  wire logic                   rsp_read_req,
  input  wire logic                   host_wr,
  input  wire logic [RQI_FIELD_W-1:0] host_wdata,
  output logic [RQI_FIELD_W-1:0]      int_flags,
  output logic                        req_read_grant,
  output logic                        rsp_read_grant,
  output logic                        req_read_blocked,
  output logic                        rsp_read_blocked
);

  localparam int LB_REQ_ERR = RQI_BIT_REQ_ERR - RQI_FIELD_LSB;
  localparam int LB_RSP_ERR = RQI_BIT_RSP_ERR - RQI_FIELD_LSB;
  localparam int LB_REQ_QAV = RQI_BIT_REQ_QAV - RQI_FIELD_LSB;
  localparam int LB_RSP_QAV = RQI_BIT_RSP_QAV - RQI_FIELD_LSB;

  // Four flags over two queues is all the bit mapping below can serve
  if (RQI_FIELD_W != 4 || RQI_NUM_QUEUES != 2)
  begin : g_bad_layout
    $error("rqi_rx_queue_flags: field layout unsupported");
  end

  // Highest and lowest flag positions (response error, request quadlet) must fall inside the owned field
  if (LB_RSP_ERR >= RQI_FIELD_W || LB_REQ_QAV < 0)
  begin : g_bad_position
    $error("rqi_rx_queue_flags: flag position outside field");
  end

  logic [RQI_NUM_QUEUES-1:0] xerr;
  logic [RQI_NUM_QUEUES-1:0] clr;
  logic [RQI_NUM_QUEUES-1:0] qav;
  logic [RQI_NUM_QUEUES-1:0] rd_req;
  logic [RQI_NUM_QUEUES-1:0] rd_ok;
  logic [RQI_NUM_QUEUES-1:0] err_f;
  logic [RQI_NUM_QUEUES-1:0] qav_f;
  logic [RQI_NUM_QUEUES-1:0] blk;

  ////////////////////////////////////////////////////////////////////////////
  // Per-queue inputs gathered into vectors
  assign xerr[RQI_Q_REQ]   = req_xfer_error;
  assign xerr[RQI_Q_RSP]   = rsp_xfer_error;
  assign clr[RQI_Q_REQ]    = host_wr && host_wdata[LB_REQ_ERR];
  assign clr[RQI_Q_RSP]    = host_wr && host_wdata[LB_RSP_ERR];
  assign qav[RQI_Q_REQ]    = req_quadlet_avail;
  assign qav[RQI_Q_RSP]    = rsp_quadlet_avail;
  assign rd_req[RQI_Q_REQ] = req_read_req;
  assign rd_req[RQI_Q_RSP] = rsp_read_req;

  ////////////////////////////////////////////////////////////////////////////
  // One flag pair per queue; a blocked read never counts as a read
  generate
    for (genvar q = 0; q < RQI_NUM_QUEUES; q++)
    begin : g_q
      assign rd_ok[q] = rd_req[q] && !blk[q];
      rqi_queue_flags u_flags (
        .core_clk           (core_clk),
        .reset              (reset),
        .xfer_error         (xerr[q]),
        .bus_reset          (bus_reset),
        .err_clear_wr       (clr[q]),
        .quadlet_avail      (qav[q]),
        .quadlet_read       (rd_ok[q]),
        .read_error_flag    (err_f[q]),
        .quadlet_ready_flag (qav_f[q]),
        .read_block         (blk[q])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt word: flags mirror the internal state one cycle later
  always_ff @(posedge core_clk)
  begin
    if (reset)
      int_flags <= '0;
    else
    begin
      int_flags[LB_REQ_ERR] <= err_f[RQI_Q_REQ];
      int_flags[LB_RSP_ERR] <= err_f[RQI_Q_RSP];
      int_flags[LB_REQ_QAV] <= qav_f[RQI_Q_REQ];
      int_flags[LB_RSP_QAV] <= qav_f[RQI_Q_RSP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant is registered, so the queue datapath sees it a cycle after
  // the request; this trades latency for a clean flop-driven output.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      req_read_grant <= 1'b0;
      rsp_read_grant <= 1'b0;
    end
    else
    begin
      req_read_grant <= rd_ok[RQI_Q_REQ];
      rsp_read_grant <= rd_ok[RQI_Q_RSP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block status for the datapath; lags the internal flag by one cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      req_read_blocked <= 1'b0;
      rsp_read_blocked <= 1'b0;
    end
    else
    begin
      req_read_blocked <= blk[RQI_Q_REQ];
      rsp_read_blocked <= blk[RQI_Q_RSP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks, request queue
  // Events reach the word two edges after they are sampled

  // Error event shows in the word
  AST_REQ_ERR_SET: assert property (@(posedge core_clk) disable iff (reset)
    (req_xfer_error || bus_reset) |=> ##1 int_flags[LB_REQ_ERR])
    else $error("request error flag not set");

  // Error event wins over a clearing write in the same cycle
  AST_REQ_ERR_INT: assert property (@(posedge core_clk) disable iff (reset)
    (req_xfer_error || bus_reset) |=> err_f[RQI_Q_REQ])
    else $error("request error event lost");

  // No grant while the word shows the error
  AST_REQ_BLOCK: assert property (@(posedge core_clk) disable iff (reset)
    int_flags[LB_REQ_ERR] |-> !req_read_grant)
    else $error("request read granted while in error");

  // Block output follows the flag
  AST_REQ_BLOCKED_ON: assert property (@(posedge core_clk) disable iff (reset)
    err_f[RQI_Q_REQ] |=> req_read_blocked)
    else $error("request block output missing");

  // Accepted read is always granted
  AST_REQ_GRANT: assert property (@(posedge core_clk) disable iff (reset)
    (req_read_req && !blk[RQI_Q_REQ]) |=> req_read_grant)
    else $error("request read not granted");

  // Grant never appears without a request
  AST_REQ_GRANT_PULSE: assert property (@(posedge core_clk) disable iff (reset)
    !req_read_req |=> !req_read_grant)
    else $error("request grant without request");

  // A refused read must not consume the quadlet
  AST_REQ_QAV_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (qav_f[RQI_Q_REQ] && !(req_read_req && !blk[RQI_Q_REQ])) |=> qav_f[RQI_Q_REQ])
    else $error("request quadlet flag lost without read");

  // Write of one clears the flag when no event competes
  AST_REQ_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    (host_wr && host_wdata[LB_REQ_ERR] && !req_xfer_error && !bus_reset)
    |=> ##1 !int_flags[LB_REQ_ERR])
    else $error("request error flag not cleared");

  // Flag holds until written
  AST_REQ_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    (err_f[RQI_Q_REQ] && !(host_wr && host_wdata[LB_REQ_ERR]))
    |=> err_f[RQI_Q_REQ])
    else $error("request error flag dropped without write");

  // Clearing the flag releases the block
  AST_REQ_BLOCKED_OFF: assert property (@(posedge core_clk) disable iff (reset)
    !err_f[RQI_Q_REQ] |=> !req_read_blocked)
    else $error("request block output stuck");

  // Quadlet available shows in the word
  AST_REQ_QAV_SET: assert property (@(posedge core_clk) disable iff (reset)
    req_quadlet_avail |=> ##1 int_flags[LB_REQ_QAV])
    else $error("request quadlet flag not set");

  // Accepted read clears the quadlet flag
  AST_REQ_QAV: assert property (@(posedge core_clk) disable iff (reset)
    (req_read_req && !blk[RQI_Q_REQ] && !req_quadlet_avail)
    |=> ##1 !int_flags[LB_REQ_QAV])
    else $error("request quadlet flag not cleared by read");

  ////////////////////////////////////////////////////////////////////////////
  // Checks, response queue

  // Quadlet available shows in the word
  AST_RSP_QAV: assert property (@(posedge core_clk) disable iff (reset)
    rsp_quadlet_avail |=> ##1 int_flags[LB_RSP_QAV])
    else $error("response quadlet flag not set");

  // Accepted read clears the quadlet flag
  AST_RSP_QAV_CLR: assert property (@(posedge core_clk) disable iff (reset)
    (rsp_read_req && !rsp_read_blocked && !blk[RQI_Q_RSP] && !rsp_quadlet_avail)
    |=> ##1 !int_flags[LB_RSP_QAV])
    else $error("response quadlet flag not cleared by read");

  // Error event sets the flag and holds off the grant
  AST_RSP_ERR: assert property (@(posedge core_clk) disable iff (reset)
    (rsp_xfer_error || bus_reset) |=> ##1 (int_flags[LB_RSP_ERR] && !rsp_read_grant))
    else $error("response error flag or block wrong");

  // No grant while the word shows the error
  AST_RSP_BLOCK: assert property (@(posedge core_clk) disable iff (reset)
    int_flags[LB_RSP_ERR] |-> !rsp_read_grant)
    else $error("response read granted while in error");

  // A refused read must not consume the quadlet
  AST_RSP_QAV_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (qav_f[RQI_Q_RSP] && !(rsp_read_req && !blk[RQI_Q_RSP])) |=> qav_f[RQI_Q_RSP])
    else $error("response quadlet flag lost without read");

  // Write of one clears the flag when no event competes
  AST_RSP_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    (host_wr && host_wdata[LB_RSP_ERR] && !rsp_xfer_error && !bus_reset)
    |=> ##1 !int_flags[LB_RSP_ERR])
    else $error("response error flag not cleared");

  // Flag holds until written
  AST_RSP_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    (err_f[RQI_Q_RSP] && !(host_wr && host_wdata[LB_RSP_ERR]))
    |=> err_f[RQI_Q_RSP])
    else $error("response error flag dropped without write");

  // Block output follows the flag
  AST_RSP_BLOCKED_ON: assert property (@(posedge core_clk) disable iff (reset)
    err_f[RQI_Q_RSP] |=> rsp_read_blocked)
    else $error("response block output missing");

endmodule : rqi_rx_queue_flags

// ==== rqi_pkg.sv ====
package rqi_pkg;
  // Flag positions within the interrupt word
  localparam int RQI_BIT_RSP_ERR = 11;
  localparam int RQI_BIT_REQ_ERR = 10;
  localparam int RQI_BIT_RSP_QAV = 9;
  localparam int RQI_BIT_REQ_QAV = 8;
  // Field of the interrupt word this block owns
  localparam int RQI_FIELD_LSB   = 8;
  localparam int RQI_FIELD_W     = 4;
  // Number of receive queues handled
  localparam int RQI_NUM_QUEUES  = 2;
  // Queue indices
  localparam int RQI_Q_REQ       = 0;
  localparam int RQI_Q_RSP       = 1;
  // Reset value of a flag
  localparam logic RQI_FLAG_RST  = 1'b0;
  // Flag lifecycle
  typedef enum logic {RQI_IDLE, RQI_SET} rqi_flag_t;
endpackage : rqi_pkg

// ==== rqi_queue_flags.sv ====
`timescale 1ns/1ps
// One receive queue: read-error flag with read block, and quadlet-ready flag
module rqi_queue_flags
  import rqi_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic xfer_error,
  input  wire logic bus_reset,
  input  wire logic err_clear_wr,
  input  wire logic quadlet_avail,
  input  wire logic quadlet_read,
  output logic      read_error_flag,
  output logic      quadlet_ready_flag,
  output logic      read_block
);

  logic err_r;
  logic qav_r;

  // Error flag: set wins over clear so an event is never lost
  always_ff @(posedge core_clk)
  begin
    if (reset)
      err_r <= RQI_FLAG_RST;
    else if (xfer_error || bus_reset)
      err_r <= 1'b1;
    else if (err_clear_wr)
      err_r <= 1'b0;
  end

  // Quadlet ready: self-clears on read, new availability wins
  always_ff @(posedge core_clk)
  begin
    if (reset)
      qav_r <= RQI_FLAG_RST;
    else if (quadlet_avail)
      qav_r <= 1'b1;
    else if (quadlet_read)
      qav_r <= 1'b0;
  end

  assign read_error_flag    = err_r;
  assign quadlet_ready_flag = qav_r;
  assign read_block         = err_r;

endmodule : rqi_queue_flags

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
  import rqi_pkg::*;
;
  logic                   core_clk = 1'b0;
  logic                   reset    = 1'b1;
  logic                   bus_reset, req_xfer_error, rsp_xfer_error;
  logic                   req_quadlet_avail, rsp_quadlet_avail;
  logic                   req_read_req, rsp_read_req, host_wr;
  logic [RQI_FIELD_W-1:0] host_wdata, int_flags;
  logic                   req_read_grant, rsp_read_grant;
  logic                   req_read_blocked, rsp_read_blocked;
  int                     err_total    = 0;
  int                     total_checks = 0;
  int                     cycles       = 0;

  rqi_rx_queue_flags i_rqi_rx_queue_flags (.core_clk(core_clk), .reset(reset),
    .bus_reset(bus_reset), .req_xfer_error(req_xfer_error),
    .rsp_xfer_error(rsp_xfer_error), .req_quadlet_avail(req_quadlet_avail),
    .rsp_quadlet_avail(rsp_quadlet_avail), .req_read_req(req_read_req),
    .rsp_read_req(rsp_read_req), .host_wr(host_wr), .host_wdata(host_wdata),
    .int_flags(int_flags), .req_read_grant(req_read_grant),
    .rsp_read_grant(rsp_read_grant), .req_read_blocked(req_read_blocked),
    .rsp_read_blocked(rsp_read_blocked));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns period
  always #2 core_clk = ~core_clk;

  // Hang guard, far above the few dozen cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inputs move 1 ns after the edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Host write of the flag field, one-cycle strobe
  task automatic host_write(input logic [3:0] d);
    host_wr = 1'b1; host_wdata = d; tick(1);
    host_wr = 1'b0; tick(1);
  endtask : host_write

  ////////////////////////////////////////////////////////////////////////////
  // Request queue: error blocks the read, quadlet flag survives the refusal
  task automatic req_queue_case();
    req_quadlet_avail = 1'b1; req_xfer_error = 1'b1; tick(1);
    req_quadlet_avail = 1'b0; req_xfer_error = 1'b0; tick(1);
    chk(int_flags, 4'h5);
    chk({3'h0, req_read_blocked}, 4'h1);
    req_read_req = 1'b1; tick(1);
    req_read_req = 1'b0;
    chk({3'h0, req_read_grant}, 4'h0);
    tick(1);
    chk(int_flags, 4'h5);
    host_write(4'h3);
    chk(int_flags, 4'h5);
    host_write(4'h4);
    chk(int_flags, 4'h1);
    chk({3'h0, req_read_blocked}, 4'h0);
    req_read_req = 1'b1; tick(1);
    req_read_req = 1'b0;
    chk({3'h0, req_read_grant}, 4'h1);
    tick(1);
    chk(int_flags, 4'h0);
    chk({3'h0, req_read_grant}, 4'h0);
  endtask : req_queue_case

  // Bus reset raises both errors; response side cleared on its own
  task automatic rsp_queue_case();
    bus_reset = 1'b1; rsp_quadlet_avail = 1'b1; tick(1);
    bus_reset = 1'b0; rsp_quadlet_avail = 1'b0; tick(1);
    chk(int_flags, 4'hE);
    chk({3'h0, rsp_read_blocked}, 4'h1);
    rsp_read_req = 1'b1; tick(1);
    rsp_read_req = 1'b0;
    chk({3'h0, rsp_read_grant}, 4'h0);
    tick(1);
    host_write(4'h8);
    chk(int_flags, 4'h6);
    chk({3'h0, rsp_read_blocked}, 4'h0);
    host_write(4'h4);
    rsp_read_req = 1'b1; tick(1);
    rsp_read_req = 1'b0;
    chk({3'h0, rsp_read_grant}, 4'h1);
    tick(1);
    chk(int_flags, 4'h0);
    rsp_xfer_error = 1'b1; tick(1);
    rsp_xfer_error = 1'b0; tick(1);
    chk(int_flags, 4'h8);
    host_write(4'h8);
    chk(int_flags, 4'h0);
  endtask : rsp_queue_case

  // Event against clear, new quadlet against read: the set must win
  task automatic race_case();
    req_xfer_error = 1'b1; tick(1);
    host_wr = 1'b1; host_wdata = 4'h4; tick(1);
    req_xfer_error = 1'b0; host_wr = 1'b0; tick(1);
    chk(int_flags, 4'h4);
    host_write(4'h4);
    chk(int_flags, 4'h0);
    req_quadlet_avail = 1'b1; tick(1);
    req_read_req = 1'b1; tick(1);
    req_quadlet_avail = 1'b0; req_read_req = 1'b0;
    chk({3'h0, req_read_grant}, 4'h1);
    tick(1);
    chk({3'h0, req_read_grant}, 4'h0);
    chk(int_flags, 4'h1);
    req_read_req = 1'b1; tick(1);
    req_read_req = 1'b0; tick(1);
    chk(int_flags, 4'h0);
  endtask : race_case

  // Reset in mid-run wipes set flags; events work right after release
  task automatic reset_case();
    bus_reset = 1'b1; tick(1);
    bus_reset = 1'b0; reset = 1'b1; tick(2);
    reset = 1'b0; tick(1);
    chk(int_flags, 4'h0);
    chk({2'h0, req_read_blocked, rsp_read_blocked}, 4'h0);
    req_xfer_error = 1'b1; tick(1);
    req_xfer_error = 1'b0; tick(1);
    chk(int_flags, 4'h4);
    host_write(4'h4);
    chk(int_flags, 4'h0);
  endtask : reset_case

  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {bus_reset, req_xfer_error, rsp_xfer_error, req_quadlet_avail} = 4'h0;
    {rsp_quadlet_avail, req_read_req, rsp_read_req, host_wr} = 4'h0;
    host_wdata = 4'h0;
    tick(20);
    reset = 1'b0;
    tick(1);
    chk(int_flags, 4'h0);
    req_queue_case();
    rsp_queue_case();
    race_case();
    reset_case();
    wrap_up();
  end
endmodule : testbench
